// ===== verilog/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  localparam logic [7:0] OPTION_ADDR = 8'hC8;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam int LEVEL_SEL_BIT = 6;
  localparam int BC_EDGE_BIT = 5;
  localparam int GLOBAL_EN_BIT = 4;
  localparam logic [7:0] OPTION_USED_MASK = 8'h70;
  localparam logic [11:0] VEC_NMI = 12'hFFC;
  localparam logic [11:0] VEC_PORT_A = 12'hFF6;
  localparam logic [11:0] VEC_PORT_BC = 12'hFF4;
  localparam logic [11:0] VEC_TIMER = 12'hFF2;
  localparam logic [11:0] VEC_ADC = 12'hFF0;
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_IRQ = 2'b01,
    MODE_NMI = 2'b11
  } core_mode_t;
endpackage

// ===== verilog/irq_edge_if.sv
`timescale 1ns/1ps
interface irq_edge_if;
  logic pin_sync;
  logic rising_sel;
  logic clear_first;
  logic req;
  modport ctrl (output pin_sync, output rising_sel, output clear_first, input req);
  modport det (input pin_sync, input rising_sel, input clear_first, output req);
endinterface

// ===== verilog/irq_edge_latch.sv
`timescale 1ns/1ps
module irq_edge_latch (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  irq_edge_if.det port
);
  logic prev;
  logic first;
  wire edge_seen = port.rising_sel ? (port.pin_sync & ~prev) : (~port.pin_sync & prev);

  // The latch is cleared on entry, so it holds one edge seen during service and drops any further ones.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      prev <= 1'b1;
      first <= 1'b0;
    end else begin
      prev <= port.pin_sync;
      if (port.clear_first) first <= edge_seen;
      else if (edge_seen) first <= 1'b1;
    end
  end

  assign port.req = first;
endmodule

// ===== verilog/mcu_interrupt_controller.sv
// Behaviour
// - Four maskable sources plus one non-maskable.
// - Vectors FFC, FF6, FF4 for pins.
// - Timer vector FF2, converter vector FF0.
// - Accepted request loads selected vector into PC.
// - Peripheral flag reaches controller only when masked-in.
// - NMI preempts anything but an NMI service; maskables never preempt.
// - Fixed priority, vector 1 highest, 4 lowest.
// - Option register at C8, write-only, whole bytes.
// - Bit 6 selects Port A low level.
// - Bit 5 selects Port BC rising edge.
// - Bit 4 enables all maskable interrupts.
// - Disabled global enable blocks NMI wake-up.
// - Option register clears on reset.
// - NMI falling edge sets flop; entry clears it.
// - One extra edge held per port, rest lost.
// - Level mode stores nothing, sampled at boundary; the code still latches Port A edges and does not clear them.
// - Requests tested at every instruction end.
// - Entry switches flags, pushes PC, clears latch.
// - Return restores flags and pops saved PC.
`timescale 1ns/1ps
module mcu_interrupt_controller
  import irq_ctrl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_nmi_pin,
  input wire logic i_port_a_pin,
  input wire logic i_port_bc_pin,
  input wire logic i_timer_zero_flag,
  input wire logic i_timer_irq_mask,
  input wire logic i_conversion_done_flag,
  input wire logic i_adc_irq_mask,
  input wire logic i_instr_end,
  input wire logic i_return_from_interrupt_instr,
  input wire logic i_low_power,
  input wire logic i_data_wr,
  input wire logic [7:0] i_data_addr,
  input wire logic [7:0] i_data_wdata,
  output logic o_take_irq,
  output logic [11:0] o_vector_addr,
  output logic o_push_pc,
  output logic o_pop_pc,
  output logic [1:0] o_flag_set,
  output logic o_wake
);
  logic nmi_s1, nmi_s2, pa_s1, pa_s2, bc_s1, bc_s2;
  logic nmi_prev;
  logic nmi_req;
  logic [7:0] interrupt_option_reg;
  core_mode_t mode;
  core_mode_t saved_mode;
  irq_edge_if a_if ();
  irq_edge_if bc_if ();

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      nmi_s1 <= 1'b1;
      nmi_s2 <= 1'b1;
      pa_s1 <= 1'b1;
      pa_s2 <= 1'b1;
      bc_s1 <= 1'b1;
      bc_s2 <= 1'b1;
    end else begin
      nmi_s1 <= i_nmi_pin;
      nmi_s2 <= nmi_s1;
      pa_s1 <= i_port_a_pin;
      pa_s2 <= pa_s1;
      bc_s1 <= i_port_bc_pin;
      bc_s2 <= bc_s1;
    end
  end

  wire level_a = interrupt_option_reg[LEVEL_SEL_BIT];
  wire rise_bc = interrupt_option_reg[BC_EDGE_BIT];
  wire global_irq_enable = interrupt_option_reg[GLOBAL_EN_BIT];

  wire option_write = i_data_wr && (i_data_addr == OPTION_ADDR);

  // Only the defined bits are stored, so writes to the unused bits have no effect.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) interrupt_option_reg <= OPTION_RESET;
    else if (option_write) interrupt_option_reg <= i_data_wdata & OPTION_USED_MASK;
  end

  // A falling NMI edge sets the request; an edge in the entry cycle wins over the clear.
  wire nmi_fall = nmi_prev & ~nmi_s2;
  wire accept_boundary = i_instr_end | i_low_power;
  wire take_nmi = accept_boundary && nmi_req && (mode != MODE_NMI) && (!i_low_power || global_irq_enable);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      nmi_prev <= 1'b1;
      nmi_req <= 1'b0;
    end else begin
      nmi_prev <= nmi_s2;
      if (nmi_fall) nmi_req <= 1'b1;
      else if (take_nmi) nmi_req <= 1'b0;
    end
  end

  assign a_if.pin_sync = pa_s2;
  assign a_if.rising_sel = 1'b0;
  assign bc_if.pin_sync = bc_s2;
  assign bc_if.rising_sel = rise_bc;

  irq_edge_latch u_latch_a (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .port(a_if.det)
  );
  irq_edge_latch u_latch_bc (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .port(bc_if.det)
  );

  // Level mode reads the pin directly at the boundary; the Port A edge latch still records falling edges and is not cleared.
  wire req_a = level_a ? ~pa_s2 : a_if.req;
  wire req_bc = bc_if.req;
  wire req_tim = i_timer_zero_flag & i_timer_irq_mask;
  wire req_adc = i_conversion_done_flag & i_adc_irq_mask;

  wire any_mask = req_a | req_bc | req_tim | req_adc;
  wire take_mask = accept_boundary && !take_nmi && global_irq_enable && any_mask && (mode == MODE_NORMAL);

  wire [11:0] mask_vec = req_a ? VEC_PORT_A :
                         req_bc ? VEC_PORT_BC :
                         req_tim ? VEC_TIMER : VEC_ADC;
  wire [11:0] sel_vec = take_nmi ? VEC_NMI : mask_vec;

  wire clr_a = take_mask && req_a && !level_a;
  wire clr_bc = take_mask && !req_a && req_bc;
  assign a_if.clear_first = clr_a;
  assign bc_if.clear_first = clr_bc;

  wire entering = take_nmi | take_mask;
  wire leaving = i_return_from_interrupt_instr && !entering && (mode != MODE_NORMAL);

  // Flag-set tracking: NMI remembers the interrupted mode so return can restore it.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mode <= MODE_NMI;
      saved_mode <= MODE_NORMAL;
    end else if (take_nmi) begin
      saved_mode <= mode;
      mode <= MODE_NMI;
    end else if (take_mask) begin
      mode <= MODE_IRQ;
    end else if (leaving) begin
      mode <= (mode == MODE_NMI) ? saved_mode : MODE_NORMAL;
      saved_mode <= MODE_NORMAL;
    end
  end

  wire wake_now = i_low_power && global_irq_enable && (nmi_req || any_mask);

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_take_irq <= 1'b0;
      o_vector_addr <= VEC_ADC;
      o_push_pc <= 1'b0;
      o_pop_pc <= 1'b0;
      o_flag_set <= MODE_NMI;
      o_wake <= 1'b0;
    end else begin
      o_take_irq <= entering;
      if (entering) o_vector_addr <= sel_vec;
      o_push_pc <= entering;
      o_pop_pc <= leaving;
      o_flag_set <= take_nmi ? MODE_NMI : take_mask ? MODE_IRQ :
                    leaving ? ((mode == MODE_NMI) ? saved_mode : MODE_NORMAL) : mode;
      o_wake <= wake_now;
    end
  end
endmodule

// ===== test/irq_chk_asserts.sv
`timescale 1ns/1ps
module irq_chk
  import irq_ctrl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic i_instr_end,
  input wire logic i_low_power,
  input wire logic i_return_from_interrupt_instr,
  input wire logic o_take_irq,
  input wire logic o_push_pc,
  input wire logic o_pop_pc,
  input wire logic [11:0] o_vector_addr,
  input wire logic [1:0] o_flag_set
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  entry_at_boundary_a: assert property (o_take_irq |-> $past(i_instr_end || i_low_power))
    else $error("entry without boundary");
  pop_after_return_a: assert property (o_pop_pc |-> $past(i_return_from_interrupt_instr))
    else $error("pop without return");
  entry_pushes_pc_a: assert property (o_take_irq |-> o_push_pc && o_flag_set != MODE_NORMAL)
    else $error("entry without push");
  nmi_flag_set_a: assert property (o_take_irq && o_vector_addr == VEC_NMI |-> o_flag_set == MODE_NMI)
    else $error("nmi entry flag set wrong");
  no_preempt_a: assert property (o_take_irq && o_vector_addr != VEC_NMI |->
    $past(o_flag_set) == MODE_NORMAL && o_flag_set == MODE_IRQ) else $error("maskable preempted");
  nmi_no_reentry_a: assert property ($past(o_flag_set) == MODE_NMI |-> !o_take_irq)
    else $error("entry in nmi mode");
  vector_holds_a: assert property (!o_take_irq && !$past(i_sys_rst) |-> $stable(o_vector_addr))
    else $error("vector moved");
  flag_holds_a: assert property (!o_take_irq && !o_pop_pc && !$past(i_sys_rst) |-> $stable(o_flag_set))
    else $error("flag set moved");
endmodule
bind mcu_interrupt_controller irq_chk chk (.*);

// ===== test/periph_model.sv
`timescale 1ns/1ps
module periph_model (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_fire,
  input wire logic [1:0] i_ack,
  output logic [1:0] o_flag
);
  // A request flag stays set until the service routine clears it.
  always_ff @(posedge i_sys_clk) begin
    o_flag <= i_sys_rst ? 2'h0 : (o_flag | i_fire) & ~i_ack;
  end
endmodule

// ===== test/mcu_interrupt_controller_tb.sv
`timescale 1ns/1ps
module mcu_interrupt_controller_tb;
  import irq_ctrl_pkg::*;
  logic i_sys_clk = 1'h0;
  logic i_sys_rst = 1'h1;
  logic nmi = 1'h1, pa = 1'h1, pbc = 1'h1, tm = 1'h0, am = 1'h0, ie = 1'h0, rt = 1'h0, wr = 1'h0;
  logic [7:0] wd = 8'h00;
  logic [7:0] ad = OPTION_ADDR;
  logic lp = 1'h0;
  logic wk;
  logic [1:0] fire = 2'h0, ack = 2'h0, flg, fs;
  logic take, push, pop;
  logic [11:0] vec;
  int n_fail = 0;
  int cmp_count = 0;
  initial forever #20 i_sys_clk = ~i_sys_clk;
  periph_model PM (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_fire(fire), .i_ack(ack), .o_flag(flg));
  mcu_interrupt_controller DUT (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_nmi_pin(nmi), .i_port_a_pin(pa),
    .i_port_bc_pin(pbc), .i_timer_zero_flag(flg[0]), .i_timer_irq_mask(tm), .i_conversion_done_flag(flg[1]),
    .i_adc_irq_mask(am), .i_instr_end(ie), .i_return_from_interrupt_instr(rt), .i_low_power(lp),
    .i_data_wr(wr), .i_data_addr(ad), .i_data_wdata(wd), .o_take_irq(take), .o_vector_addr(vec),
    .o_push_pc(push), .o_pop_pc(pop), .o_flag_set(fs), .o_wake(wk));
  task automatic tk(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wio(input logic [7:0] d);
    wr = 1'h1;
    wd = d;
    tk(1);
    wr = 1'h0;
  endtask
  task automatic bnd(input logic t, input logic [11:0] v);
    ie = 1'h1;
    tk(1);
    ie = 1'h0;
    chk(12'(take), 12'(t));
    chk(12'(push), 12'(t));
    if (t) chk(vec, v);
  endtask
  task automatic ret(input logic [1:0] m);
    rt = 1'h1;
    tk(1);
    rt = 1'h0;
    chk(12'(pop), 12'h001);
    chk(12'(fs), 12'(m));
  endtask
  task automatic tg(input int n);
    repeat (n) begin
      pa = 1'h0;
      tk(4);
      pa = 1'h1;
      tk(4);
    end
  endtask
  task automatic end_of_test;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    end_of_test;
  end
  initial begin
    tk(20);
    i_sys_rst = 1'h0;
    chk(12'(fs), 12'(MODE_NMI));
    tm = 1'h1;
    am = 1'h1;
    fire = 2'h3;
    tk(1);
    fire = 2'h0;
    bnd(1'h0, 12'h000);
    ret(MODE_NORMAL);
    bnd(1'h0, 12'h000);
    wio(8'h8F);
    bnd(1'h0, 12'h000);
    wio(8'h10);
    bnd(1'h1, VEC_TIMER);
    bnd(1'h0, 12'h000);
    nmi = 1'h0;
    tk(4);
    bnd(1'h1, VEC_NMI);
    nmi = 1'h1;
    ret(MODE_IRQ);
    ack = 2'h1;
    ret(MODE_NORMAL);
    ack = 2'h0;
    bnd(1'h1, VEC_ADC);
    ret(MODE_NORMAL);
    tm = 1'h0;
    am = 1'h0;
    bnd(1'h0, 12'h000);
    $display("test peripherals done");
    tg(1);
    bnd(1'h1, VEC_PORT_A);
    tg(2);
    ret(MODE_NORMAL);
    bnd(1'h1, VEC_PORT_A);
    ret(MODE_NORMAL);
    bnd(1'h0, 12'h000);
    wio(8'h30);
    pbc = 1'h0;
    tk(4);
    bnd(1'h0, 12'h000);
    pbc = 1'h1;
    tk(4);
    bnd(1'h1, VEC_PORT_BC);
    ret(MODE_NORMAL);
    $display("test edges done");
    wio(8'h50);
    pa = 1'h0;
    tk(4);
    bnd(1'h1, VEC_PORT_A);
    ret(MODE_NORMAL);
    bnd(1'h1, VEC_PORT_A);
    pa = 1'h1;
    tk(4);
    ret(MODE_NORMAL);
    bnd(1'h0, 12'h000);
    $display("test level done");
    ad = 8'hC9;
    wio(8'h00);
    ad = OPTION_ADDR;
    pa = 1'h0;
    tk(4);
    bnd(1'h1, VEC_PORT_A);
    pa = 1'h1;
    tk(4);
    ret(MODE_NORMAL);
    wio(8'h00);
    bnd(1'h0, 12'h000);
    nmi = 1'h0;
    tk(4);
    nmi = 1'h1;
    lp = 1'h1;
    tk(2);
    chk(12'(wk), 12'h000);
    chk(12'(take), 12'h000);
    wio(8'h10);
    tk(1);
    chk(12'(take), 12'h001);
    chk(12'(wk), 12'h001);
    chk(vec, VEC_NMI);
    lp = 1'h0;
    ret(MODE_NORMAL);
    bnd(1'h1, VEC_PORT_A);
    ret(MODE_NORMAL);
    $display("test address and wake done");
    end_of_test;
  end
endmodule
